// ---- nuf_host.sv ----
// Purpose: host controller issuing unique id, set features and get features to a NAND target
// Assumes: Wishbone classic slave, one asynchronous NAND target, 50 MHz clock
// Notes: busy waited on R/B#, then read mode issued before unique id and get features data output; random data read outputs after the tCCS gap that follows E0h
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module nuf_host
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // NAND pins
  output logic o_nand_ce_n,
  output logic o_nand_cle,
  output logic o_nand_ale,
  output logic o_nand_we_n,
  output logic o_nand_re_n,
  output logic o_nand_wp_n,
  output logic [7:0] o_nand_io,
  output logic o_nand_io_oe_n,
  input wire logic [15:0] i_nand_io,
  input wire logic i_nand_rb_n
);
  typedef enum logic [3:0] {
    H_IDLE, H_CMD, H_ADDR, H_PARAM, H_WAIT_BUSY, H_WAIT_RDY, H_RDMODE, H_READ,
    H_RCMD2, H_DONE
  } nuf_hs_e;

  nuf_hs_e st_reg, st_next;
  logic [2:0] op_reg, op_next;
  logic [7:0] faddr_reg, faddr_next;
  logic [31:0] param_reg, param_next;
  logic [31:0] rdparam_reg, rdparam_next;
  logic [8:0] col_reg, col_next;
  logic [8:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic err_reg, err_next;
  logic uid_ok_reg, uid_ok_next;
  logic [4:0] copy_reg, copy_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic go_req;
  logic seq_valid;
  nuf_pkg::nuf_req_s seq_req;
  logic seq_ready;
  logic seq_done;
  logic [7:0] seq_rdata;
  nuf_pkg::nuf_pins_s pins;
  logic chk_start;
  logic chk_valid;
  logic chk_end;
  logic chk_good;
  logic [127:0] chk_uid;
  logic wb_write;
  logic reserved_fa;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sequencer and identifier checker
  nuf_pin_seq u_seq
  (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_valid(seq_valid),
    .i_req(seq_req),
    .o_ready(seq_ready),
    .o_done(seq_done),
    .o_rdata(seq_rdata),
    .o_pins(pins),
    .o_io(o_nand_io),
    .o_io_oe_n(o_nand_io_oe_n),
    .i_io(i_nand_io)
  );

  nuf_uid_check u_chk
  (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_start(chk_start),
    .i_valid(chk_valid),
    .i_byte(seq_rdata),
    .o_copy_end(chk_end),
    .o_good(chk_good),
    .o_uid(chk_uid)
  );

  assign o_nand_ce_n = pins.ce_n;
  assign o_nand_cle = pins.cle;
  assign o_nand_ale = pins.ale;
  assign o_nand_we_n = pins.we_n;
  assign o_nand_re_n = pins.re_n;
  assign o_nand_wp_n = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  assign wb_write = i_wb_cyc && i_wb_stb && i_wb_we && !ack_reg;
  assign go_req = wb_write && (i_wb_adr == nuf_pkg::REG_CTRL) && i_wb_sel[0];
  // Reserved feature addresses are refused rather than sent
  assign reserved_fa = !((faddr_reg == nuf_pkg::FA_TIMING) || (faddr_reg == nuf_pkg::FA_DRIVE) ||
    (faddr_reg == nuf_pkg::FA_PULLDN) || (faddr_reg == nuf_pkg::FA_ARRAY));

  always_comb
  begin
    rdat_next = rdat_reg;
    ack_next = i_wb_cyc && i_wb_stb && !ack_reg;
    if (i_wb_cyc && i_wb_stb && !i_wb_we && !ack_reg)
    begin
      rdat_next = 32'h00000000;
      if (i_wb_adr == nuf_pkg::REG_FADDR)
        rdat_next = {24'h000000, faddr_reg};
      else if (i_wb_adr == nuf_pkg::REG_PARAM)
        rdat_next = param_reg;
      else if (i_wb_adr == nuf_pkg::REG_STATUS)
        rdat_next = {24'h000000, copy_reg, uid_ok_reg, err_reg, busy_reg};
      else if (i_wb_adr == nuf_pkg::REG_RDPARAM)
        rdat_next = rdparam_reg;
      else if (i_wb_adr == nuf_pkg::REG_COL)
        rdat_next = {23'h000000, col_reg};
      else if (i_wb_adr[7:4] == nuf_pkg::REG_UID_BASE[7:4])
        rdat_next = chk_uid[{i_wb_adr[3:2], 5'h00} +: 32];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_comb
  begin
    st_next = st_reg;
    op_next = op_reg;
    faddr_next = faddr_reg;
    param_next = param_reg;
    rdparam_next = rdparam_reg;
    col_next = col_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    err_next = err_reg;
    uid_ok_next = uid_ok_reg;
    copy_next = copy_reg;
    seq_valid = 1'b0;
    seq_req = '{kind: nuf_pkg::CYC_CMD, data: 8'h00, gap: nuf_pkg::WB_CYC};
    chk_start = 1'b0;
    chk_valid = 1'b0;
    if (wb_write && !busy_reg)
    begin
      if (i_wb_adr == nuf_pkg::REG_FADDR)
        faddr_next = i_wb_dat[7:0];
      else if (i_wb_adr == nuf_pkg::REG_PARAM)
        param_next = i_wb_dat;
      else if (i_wb_adr == nuf_pkg::REG_COL)
        col_next = i_wb_dat[8:0];
    end
    unique case (st_reg)
      H_IDLE:
      begin
        // Idle target only: a new operation starts after the last busy ended
        if (go_req && (i_wb_dat[2:0] != 3'h0) && i_nand_rb_n)
        begin
          op_next = i_wb_dat[2:0];
          err_next = 1'b0;
          busy_next = 1'b1;
          if ((i_wb_dat[2:0] != nuf_pkg::OP_UID) && (i_wb_dat[2:0] != nuf_pkg::OP_RAND) &&
            reserved_fa)
          begin
            err_next = 1'b1;
            busy_next = 1'b0;
          end
          else
          begin
            if (i_wb_dat[2:0] == nuf_pkg::OP_UID)
            begin
              uid_ok_next = 1'b0;
              copy_next = 5'h00;
              col_next = 9'h000;
            end
            st_next = H_CMD;
          end
        end
      end
      H_CMD:
      begin
        seq_valid = seq_ready;
        if (op_reg == nuf_pkg::OP_UID)
          seq_req.data = nuf_pkg::CMD_UNIQUE_ID;
        else if (op_reg == nuf_pkg::OP_SET)
          seq_req.data = nuf_pkg::CMD_SET_FEAT;
        else if (op_reg == nuf_pkg::OP_GET)
          seq_req.data = nuf_pkg::CMD_GET_FEAT;
        else
          seq_req.data = nuf_pkg::CMD_RAND_READ1;
        if (seq_done)
        begin
          st_next = H_ADDR;
          cnt_next = 9'h000;
        end
      end
      H_ADDR:
      begin
        seq_valid = seq_ready;
        seq_req.kind = nuf_pkg::CYC_ADDR;
        if (op_reg == nuf_pkg::OP_UID)
          seq_req.data = nuf_pkg::UID_ADDR;
        else if (op_reg == nuf_pkg::OP_RAND)
          seq_req.data = (cnt_reg == 9'h000) ? col_reg[7:0] : {7'h00, col_reg[8]};
        else
          seq_req.data = faddr_reg;
        if (op_reg == nuf_pkg::OP_SET)
          seq_req.gap = nuf_pkg::ADL_CYC;
        if (seq_done)
        begin
          cnt_next = 9'h000;
          if (op_reg == nuf_pkg::OP_SET)
            st_next = H_PARAM;
          else if (op_reg == nuf_pkg::OP_RAND)
          begin
            cnt_next = cnt_reg + 9'h001;
            if (cnt_reg == 9'h001)
              st_next = H_RCMD2;
          end
          else
            st_next = H_WAIT_BUSY;
        end
      end
      H_PARAM:
      begin
        seq_valid = seq_ready;
        seq_req.kind = nuf_pkg::CYC_DIN;
        seq_req.data = param_reg[{cnt_reg[1:0], 3'h0} +: 8];
        if (seq_done)
        begin
          cnt_next = cnt_reg + 9'h001;
          if (cnt_reg == 9'h003)
            st_next = H_WAIT_BUSY;
        end
      end
      H_WAIT_BUSY:
      begin
        // R/B# falls within tWB; the sequencer gap already covered it
        st_next = H_WAIT_RDY;
      end
      H_WAIT_RDY:
      begin
        // Busy length (tR, tFEAT or tITC) is whatever the target shows on R/B#
        if (i_nand_rb_n)
        begin
          if (op_reg == nuf_pkg::OP_SET)
            st_next = H_DONE;
          else
            st_next = H_RDMODE;
        end
      end
      H_RDMODE:
      begin
        // Read mode restores data output even if status was polled meanwhile
        seq_valid = seq_ready;
        seq_req.data = nuf_pkg::CMD_READ_MODE;
        seq_req.gap = nuf_pkg::WHR_CYC;
        if (seq_done)
        begin
          st_next = H_READ;
          cnt_next = 9'h000;
          chk_start = 1'b1;
        end
      end
      H_RCMD2:
      begin
        seq_valid = seq_ready;
        seq_req.data = nuf_pkg::CMD_RAND_READ2;
        seq_req.gap = nuf_pkg::CCS_CYC;
        if (seq_done)
        begin
          st_next = H_READ;
          cnt_next = 9'h000;
          op_next = nuf_pkg::OP_UID;
          chk_start = 1'b1;
        end
      end
      H_READ:
      begin
        seq_valid = seq_ready;
        seq_req.kind = nuf_pkg::CYC_DOUT;
        seq_req.gap = 8'h01;
        if (seq_done)
        begin
          cnt_next = cnt_reg + 9'h001;
          if (op_reg == nuf_pkg::OP_GET)
          begin
            rdparam_next[{cnt_reg[1:0], 3'h0} +: 8] = seq_rdata;
            if (cnt_reg == 9'h003)
              st_next = H_DONE;
          end
          else
          begin
            chk_valid = 1'b1;
            col_next = col_reg + 9'h001;
            if (cnt_reg == (nuf_pkg::UID_COPY_BYTES - 9'h001))
            begin
              seq_valid = 1'b0;
              st_next = H_DONE;
            end
          end
        end
      end
      H_DONE:
      begin
        if (op_reg == nuf_pkg::OP_UID)
        begin
          // Wait one cycle for the checker verdict on the copy just read
          if (chk_end)
          begin
            copy_next = copy_reg + 5'h01;
            if (chk_good)
            begin
              uid_ok_next = 1'b1;
              busy_next = 1'b0;
              st_next = H_IDLE;
            end
            else if (copy_reg == 5'(nuf_pkg::UID_COPIES - 1))
            begin
              err_next = 1'b1;
              busy_next = 1'b0;
              st_next = H_IDLE;
            end
            else
            begin
              st_next = H_READ;
              cnt_next = 9'h000;
              chk_start = 1'b1;
            end
          end
        end
        else
        begin
          busy_next = 1'b0;
          st_next = H_IDLE;
        end
      end
      default: st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      st_reg <= H_IDLE;
      op_reg <= 3'h0;
      faddr_reg <= nuf_pkg::FA_TIMING;
      param_reg <= 32'h00000000;
      rdparam_reg <= 32'h00000000;
      col_reg <= 9'h000;
      cnt_reg <= 9'h000;
      busy_reg <= 1'b0;
      err_reg <= 1'b0;
      uid_ok_reg <= 1'b0;
      copy_reg <= 5'h00;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end
    else
    begin
      st_reg <= st_next;
      op_reg <= op_next;
      faddr_reg <= faddr_next;
      param_reg <= param_next;
      rdparam_reg <= rdparam_next;
      col_reg <= col_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      err_reg <= err_next;
      uid_ok_reg <= uid_ok_next;
      copy_reg <= copy_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;
endmodule // nuf_host
`default_nettype wire

// ---- nuf_host_asserts.sv ----
// Purpose: port checks for nuf_host
// Assumes: one clock, synchronous reset
// Notes: bound from the bench
`timescale 1ns/10ps
`default_nettype none
module nuf_host_asserts
(
  // Bus
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  // NAND
  input wire logic o_nand_cle,
  input wire logic o_nand_we_n,
  input wire logic o_nand_re_n,
  input wire logic o_nand_io_oe_n,
  input wire logic [7:0] o_nand_io,
  input wire logic i_nand_rb_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_we;
    !o_nand_we_n [*2] ##1 o_nand_we_n;
  endsequence
  a_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  a_we_width: assert property ($fell(o_nand_we_n) |-> s_we) else $error("we");
  a_re_width: assert property ($fell(o_nand_re_n) |=> !o_nand_re_n ##1 o_nand_re_n)
    else $error("re");
  a_read_ready: assert property (!o_nand_re_n |-> i_nand_rb_n && o_nand_io_oe_n)
    else $error("read busy");
  a_write_drive: assert property (!o_nand_we_n |-> o_nand_re_n && !o_nand_io_oe_n)
    else $error("write oe");
  // Codes E0h..FFh cover id, feature and column commands
  a_idle_issue: assert property (!o_nand_we_n && o_nand_cle && o_nand_io[7:5] == 3'h7
    |-> i_nand_rb_n) else $error("busy cmd");
  a_io_hold: assert property ($fell(o_nand_we_n) |=> $stable(o_nand_io) [*2])
    else $error("io moved");
endmodule // nuf_host_asserts
`default_nettype wire

// ---- nuf_nand_model.sv ----
// Purpose: NAND target model for id and feature commands
// Assumes: x16 target, one LUN, CE# held low by the host
// Notes: i_bad0 spoils copy 0 so the host must retry
`timescale 1ns/10ps
`default_nettype none
module nuf_nand_model
(
  // Pins
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic [7:0] i_io,
  output logic [15:0] o_io,
  output logic o_rb_n,
  output logic o_ccs_err,
  // Behaviour
  input wire logic i_bad0,
  input wire logic i_slow
);
  logic [7:0] mode = 8'h00, last = 8'h00, fa = 8'h00, d;
  logic [7:0] feat [4][4] = '{default: 8'h00};
  logic [8:0] col = 9'h000;
  logic [1:0] pi = 2'h0;
  logic ac = 1'b0;
  time t_cmd = 0;
  initial o_rb_n = 1'b1;
  initial o_ccs_err = 1'b0;
  initial o_io = 16'h5AA5;
  function automatic int fx(input logic [7:0] a);
    return a == 8'h01 ? 0 : a == 8'h80 ? 1 : a == 8'h81 ? 2 : 3;
  endfunction
  // Busy starts at the strobe itself, well inside the host's gap
  task automatic go_busy();
    o_rb_n <= 1'b0;
    o_rb_n <= #((i_slow || (mode == 8'hEF && fa == 8'h01)) ? 3000 : 300) 1'b1;
  endtask
  always @(posedge i_we_n)
  begin
    if (i_cle)
    begin
      last = i_io;
      t_cmd = $time;
      ac = 1'b0;
      if (i_io inside {8'hED, 8'hEE, 8'hEF})
      begin
        mode = i_io;
        col = 9'h000;
        pi = 2'h0;
      end
    end
    else if (i_ale && last == 8'h05)
    begin
      col = ac ? {i_io[0], col[7:0]} : {1'b0, i_io};
      ac = ~ac;
    end
    else if (i_ale)
    begin
      fa = i_io;
      if (last != 8'hEF) go_busy();
    end
    else if (mode == 8'hEF)
    begin
      feat[fx(fa)][pi] = i_io;
      pi = pi + 2'h1;
      if (pi == 2'h0) go_busy();
    end
  end
  always @(negedge i_re_n)
  begin
    // Change-column setup is 100 ns (64h, 00h little-endian)
    if (last == 8'hE0 && $time - t_cmd < 100) o_ccs_err = 1'b1;
    // Copy number enters the data so a column move is visible
    d = mode == 8'hEE ? feat[fx(fa)][col[1:0]] : 8'h3C + {col[8:5], col[3:0]};
    if (mode == 8'hED && col[4]) d = ~d ^ {7'h00, i_bad0 && col[8:5] == 4'h0};
    o_io <= #5 {~d, d};
  end
  // A released bus shows the inverse so stale data never matches
  always @(posedge i_re_n)
  begin
    col = col + 9'h001;
    o_io <= #5 ~o_io;
  end
endmodule // nuf_nand_model
`default_nettype wire

// ---- nuf_pin_seq.sv ----
// Purpose: drive one NAND asynchronous bus cycle (command, address, write or read byte)
// Assumes: strobe low and high times of STROBE_CYC, then a post gap given per request
// Notes: data out is sampled on the cycle before RE# rises
`timescale 1ns/10ps
`default_nettype none
module nuf_pin_seq
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Request
  input wire logic i_valid,
  input wire nuf_pkg::nuf_req_s i_req,
  output logic o_ready,
  output logic o_done,
  output logic [7:0] o_rdata,
  // Pins
  output nuf_pkg::nuf_pins_s o_pins,
  output logic [7:0] o_io,
  output logic o_io_oe_n,
  input wire logic [15:0] i_io
);
  typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH, S_GAP} nuf_ps_e;
  nuf_ps_e st_reg, st_next;
  nuf_pkg::nuf_req_s req_reg, req_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] rd_reg, rd_next;
  nuf_pkg::nuf_pins_s pins_reg, pins_next;
  logic oe_n_reg, oe_n_next;
  logic done_reg, done_next;

  always_comb
  begin
    st_next = st_reg;
    req_next = req_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    pins_next = pins_reg;
    oe_n_next = oe_n_reg;
    done_next = 1'b0;
    unique case (st_reg)
      S_IDLE:
      begin
        if (i_valid)
        begin
          req_next = i_req;
          st_next = S_LOW;
          cnt_next = nuf_pkg::STROBE_CYC;
          pins_next.ce_n = 1'b0;
          pins_next.cle = (i_req.kind == nuf_pkg::CYC_CMD);
          pins_next.ale = (i_req.kind == nuf_pkg::CYC_ADDR);
          pins_next.re_n = (i_req.kind != nuf_pkg::CYC_DOUT);
          pins_next.we_n = (i_req.kind == nuf_pkg::CYC_DOUT);
          oe_n_next = (i_req.kind == nuf_pkg::CYC_DOUT);
        end
      end
      S_LOW:
      begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01)
        begin
          // Only the low byte is kept: upper lines are don't-care on x16 parts
          if (req_reg.kind == nuf_pkg::CYC_DOUT)
            rd_next = i_io[7:0];
          pins_next.we_n = 1'b1;
          pins_next.re_n = 1'b1;
          st_next = S_HIGH;
          cnt_next = nuf_pkg::STROBE_CYC;
        end
      end
      S_HIGH:
      begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg == 8'h01)
        begin
          pins_next.cle = 1'b0;
          pins_next.ale = 1'b0;
          oe_n_next = 1'b1;
          st_next = S_GAP;
          cnt_next = req_reg.gap;
        end
      end
      S_GAP:
      begin
        cnt_next = cnt_reg - 8'h01;
        if (cnt_reg <= 8'h01)
        begin
          st_next = S_IDLE;
          done_next = 1'b1;
        end
      end
      default: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      st_reg <= S_IDLE;
      req_reg <= '0;
      cnt_reg <= 8'h00;
      rd_reg <= 8'h00;
      pins_reg <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1};
      oe_n_reg <= 1'b1;
      done_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      req_reg <= req_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      pins_reg <= pins_next;
      oe_n_reg <= oe_n_next;
      done_reg <= done_next;
    end
  end

  // Not ready in the done cycle: a caller that steps on done must not also start a new cycle
  assign o_ready = (st_reg == S_IDLE) && !done_reg;
  assign o_done = done_reg;
  assign o_rdata = rd_reg;
  assign o_pins = pins_reg;
  assign o_io = req_reg.data;
  assign o_io_oe_n = oe_n_reg;
endmodule // nuf_pin_seq
`default_nettype wire

// ---- nuf_pkg.sv ----
// Purpose: constants and carriers for the NAND unique-id / feature host controller
// Assumes: asynchronous 8-bit NAND target, 50 MHz controller clock
// Notes: register map of the controller itself is reached over classic Wishbone
//
// Behaviour
// - Unique id and set features are issued only while the target is idle.
// - Unique id command is followed by one 00h address, then busy for read time.
// - After polling with read status, read mode command re-enables data output.
// - Host XORs copy halves, accepts on all FFh, else tries next copy.
// - Random data read pair may move the output column during id output.
// - Feature address selects four parameter bytes moved as a group.
// - After set features address, host waits address-to-data delay before data.
// - One parameter byte is taken per write enable rising edge.
package nuf_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] CMD_RAND_READ1 = 8'h05;
  localparam logic [7:0] CMD_RAND_READ2 = 8'hE0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_UNIQUE_ID = 8'hED;
  localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] UID_ADDR = 8'h00;
  // Feature addresses
  localparam logic [7:0] FA_TIMING = 8'h01;
  localparam logic [7:0] FA_DRIVE = 8'h80;
  localparam logic [7:0] FA_PULLDN = 8'h81;
  localparam logic [7:0] FA_ARRAY = 8'h90;
  // Array mode encodings, all-ones byte and status ready bit
  localparam logic [7:0] AM_NORMAL = 8'h00;
  localparam logic [7:0] AM_OTP = 8'h01;
  localparam logic [7:0] AM_OTP_PROT = 8'h03;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] STATUS_RDY_BIT = 8'h06;
  // Identifier layout
  localparam int UID_HALF = 16;
  localparam int UID_COPIES = 16;
  localparam logic [8:0] UID_COPY_BYTES = 9'h020;
  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FADDR = 8'h04;
  localparam logic [7:0] REG_PARAM = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDPARAM = 8'h10;
  localparam logic [7:0] REG_COL = 8'h14;
  localparam logic [7:0] REG_UID_BASE = 8'h20;
  // Control register operation codes
  localparam logic [2:0] OP_UID = 3'h1;
  localparam logic [2:0] OP_SET = 3'h2;
  localparam logic [2:0] OP_GET = 3'h3;
  localparam logic [2:0] OP_RAND = 3'h4;
  // Timing in ns and derived cycles at 50 MHz
  localparam int CLK_NS = 20;
  localparam int T_STROBE_NS = 30;
  localparam int T_ADL_NS = 70;
  localparam int T_WB_NS = 100;
  localparam int T_WHR_NS = 80;
  localparam int T_CCS_NS = 100;
  localparam logic [7:0] STROBE_CYC = 8'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ADL_CYC = 8'((T_ADL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WB_CYC = 8'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WHR_CYC = 8'((T_WHR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CCS_CYC = 8'((T_CCS_NS + CLK_NS - 1) / CLK_NS);

  // One bus cycle issued to the pin sequencer
  typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_DIN, CYC_DOUT} nuf_cyc_e;
  typedef struct packed {
    nuf_cyc_e kind;
    logic [7:0] data;
    logic [7:0] gap;
  } nuf_req_s;
  // NAND pins driven by the controller
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
  } nuf_pins_s;
endpackage

// ---- nuf_uid_check.sv ----
// Purpose: check unique id copies by XOR of halves as bytes stream in
// Assumes: bytes arrive in order, byte 0 of a copy first
// Notes: first 16 bytes are held, second 16 compared against their complement
`timescale 1ns/10ps
`default_nettype none
module nuf_uid_check
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Byte stream
  input wire logic i_start,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  // Result
  output logic o_copy_end,
  output logic o_good,
  output logic [127:0] o_uid
);
  logic [4:0] idx_reg, idx_next;
  logic [7:0] mem_reg [0:nuf_pkg::UID_HALF-1];
  logic ok_reg, ok_next;
  logic end_reg, end_next;
  logic good_reg, good_next;
  logic [127:0] uid_reg, uid_next;

  always_comb
  begin
    idx_next = idx_reg;
    ok_next = ok_reg;
    end_next = 1'b0;
    good_next = good_reg;
    uid_next = uid_reg;
    if (i_start)
    begin
      idx_next = 5'h00;
      ok_next = 1'b1;
      good_next = 1'b0;
    end
    else if (i_valid)
    begin
      idx_next = idx_reg + 5'h01;
      if (idx_reg[4] && ((mem_reg[idx_reg[3:0]] ^ i_byte) != nuf_pkg::ALL_ONES))
        ok_next = 1'b0;
      if (idx_reg == 5'h1F)
      begin
        end_next = 1'b1;
        good_next = ok_next;
        for (int i = 0; i < nuf_pkg::UID_HALF; i++)
          uid_next[i*8 +: 8] = mem_reg[i];
        ok_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      idx_reg <= 5'h00;
      ok_reg <= 1'b1;
      end_reg <= 1'b0;
      good_reg <= 1'b0;
      uid_reg <= '0;
    end
    else
    begin
      idx_reg <= idx_next;
      ok_reg <= ok_next;
      end_reg <= end_next;
      good_reg <= good_next;
      uid_reg <= uid_next;
    end
  end

  // Storage has no reset; it is always written before it is read
  always_ff @(posedge i_sys_clk)
  begin
    if (i_valid && !i_start && !idx_reg[4])
      mem_reg[idx_reg[3:0]] <= i_byte;
  end

  assign o_copy_end = end_reg;
  assign o_good = good_reg;
  assign o_uid = uid_reg;
endmodule // nuf_uid_check
`default_nettype wire

// ---- tb_nuf_host.sv ----
// Purpose: self-checking bench for nuf_host
// Assumes: 50 MHz clock, bench is the Wishbone master
// Notes: NAND side is nuf_nand_model
`timescale 1ns/10ps
`default_nettype none
module tb_nuf_host;
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
  logic [7:0] adr = 8'h00, io;
  logic [31:0] dat = 32'h0, rd, rdat;
  logic [15:0] mq, dq;
  logic ack, cle, ale, we_n, re_n, oe_n, rb_n, ccs_err;
  int error_cnt = 0, checks_done = 0;
  // Feature address and P1 per row
  logic [7:0] rows [6][2] = '{'{8'h01, 8'h05}, '{8'h80, 8'h03}, '{8'h81, 8'h02},
    '{8'h90, 8'h01}, '{8'h90, 8'h03}, '{8'h90, 8'h00}};
  always #10 clk = ~clk;
  assign dq = oe_n ? mq : {~io, io};
  nuf_host i_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_nand_ce_n(), .o_nand_cle(cle), .o_nand_ale(ale), .o_nand_we_n(we_n),
    .o_nand_re_n(re_n), .o_nand_wp_n(), .o_nand_io(io), .o_nand_io_oe_n(oe_n),
    .i_nand_io(dq), .i_nand_rb_n(rb_n));
  nuf_nand_model i_nand (.i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
    .i_io(dq[7:0]), .o_io(mq), .o_rb_n(rb_n), .o_ccs_err(ccs_err), .i_bad0(1'b1),
    .i_slow(slow));
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 400)
    begin
      error_cnt++;
      finish_test();
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (n = 0; n < 400 && ack !== 1'b1; n++) @(posedge clk);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    guard(n);
  endtask
  // Leaves the final status word in rd
  task automatic run(input logic [7:0] fa, input logic [7:0] p, input logic [2:0] op);
    int n;
    wb(1'b1, 8'h04, {24'h0, fa});
    wb(1'b1, 8'h08, {24'h0, p});
    wb(1'b1, 8'h00, {29'h0, op});
    rd = 32'h1;
    for (n = 0; n < 400 && rd[0] !== 1'b0; n++) wb(1'b0, 8'h0C, 32'h0);
    guard(n);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1); // feature address reset value
    wb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0); // unmapped place
    run(8'h80, 8'h00, 3'h3);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      slow <= i[0];
      run(rows[i][0], rows[i][1], 3'h2);
      run(rows[i][0], 8'h00, 3'h3);
      wb(1'b0, 8'h10, 32'h0);
      chk(rd, {24'h0, rows[i][1]});
      $display("row %0d done", i);
    end
    run(8'h01, 8'h00, 3'h1);
    chk(rd, 32'h14);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h4F4E4D4C);
    wb(1'b1, 8'h14, 32'h20);
    run(8'h01, 8'h00, 3'h4);
    wb(1'b0, 8'h2C, 32'h0);
    chk(rd, 32'h5B5A5958);
    chk({31'h0, ccs_err}, 32'h0);
    run(8'h02, 8'h01, 3'h2);
    chk(rd & 32'h2, 32'h2);
    $display("id and refusal tests done");
    finish_test();
  end
endmodule // tb_nuf_host
bind nuf_host nuf_host_asserts i_chk (.*);
`default_nettype wire
